/* File: src/sadc_edge_det.sv */
// Edge detector for one sampled input: registered copy plus rise and fall pulses.
// Assumes the input is already synchronous to clk.
module sadc_edge_det (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic sig,
  input  wire logic initVal,
  output      logic level,
  output      logic rise,
  output      logic fall
);

  logic sigPrev_q;                                  // Last sampled level

  // --------------------------------------------------------------
  // Previous-level register
  // --------------------------------------------------------------
  // Reset value is a constant 1; initVal is masked to zero at the use site and has no effect
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sigPrev_q <= 1'b1;
    end else begin
      sigPrev_q <= sig;
    end
  end

  assign level = sigPrev_q | (initVal & 1'b0);
  assign rise  = sig & ~sigPrev_q;
  assign fall  = ~sig & sigPrev_q;

endmodule

/* File: src/sadc_frame_ctrl.sv */
// Frame control and serial output of a 12-bit differential successive-approximation converter.
// Assumes chip select and serial clock come from the host, sampled on clk; both idle high.
//
// How it works
// - Chip-select fall captures the input sample
// - Serial clock drives conversion and output shift
// - Reset leaves the block in acquire
// - Frame runs from select fall to rise
// - Data output released while select is high
// - Twelve-bit results at up to 3 MSPS
// - Two's complement codes, saturating at limits
// - Only acquire, convert and calibrate states
// - Code is positive minus negative sample
// - Under 15 edges gives invalid next result
// - Leading zero, MSB first, then zeros
// - Calibrate on 24 first or 64 edges
// - First frame after power-up outputs zeros
module sadc_frame_ctrl (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  csN,
  input  wire logic                  sclk,
  input  wire sadc_pkg::sadc_sample_s sampleIn,
  output      sadc_pkg::sadc_sdo_s   sdo,
  output      sadc_pkg::sadc_state_e state,
  output      logic                  calDone,
  output      logic                  resultValid
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                     csLevel;                // Previous chip-select level
  logic                     csRise;                 // Frame end pulse
  logic                     csFall;                 // Frame start pulse
  logic                     sclkLevel;              // Previous serial-clock level
  logic                     sclkRise;               // Launch edge pulse
  logic                     sclkFall;               // Capture edge pulse
  sadc_pkg::sadc_state_e    state_q;                // Operating state
  sadc_pkg::sadc_sample_s   held_q;                 // Sample held since select fall
  logic [6:0]               edgeCnt_q;              // Falling edges in this frame
  logic [11:0]              result_q;               // Latest completed conversion
  logic                     resValid_q;             // Latest result is trustworthy
  logic                     firstFrame_q;           // No frame started since reset
  logic                     inFirst_q;              // Current frame is the first
  logic [11:0]              shift_q;                // Output shifter
  logic [3:0]               bitsLeft_q;             // Result bits still to launch
  logic                     sdoOut_q;               // Data level register
  logic                     sdoOen_q;               // Enable register, low drives
  logic                     calDone_q;              // Some calibration completed
  logic [12:0]              diff;                   // Signed difference, one guard bit
  logic [11:0]              code;                   // Saturated code

  // ----------------------------------------------------------------
  // Input edge detection
  // ----------------------------------------------------------------
  sadc_edge_det uCsEdge (
    .clk     (clk),
    .resetn  (resetn),
    .sig     (csN),
    .initVal (1'b1),
    .level   (csLevel),
    .rise    (csRise),
    .fall    (csFall)
  );

  sadc_edge_det uSclkEdge (
    .clk     (clk),
    .resetn  (resetn),
    .sig     (sclk),
    .initVal (1'b1),
    .level   (sclkLevel),
    .rise    (sclkRise),
    .fall    (sclkFall)
  );

  // ----------------------------------------------------------------
  // Transfer function
  // ----------------------------------------------------------------
  // Difference of the two held samples, clamped to the code range
  always_comb begin
    diff = {held_q.pos_analog_input[11], held_q.pos_analog_input}
         - {held_q.neg_analog_input[11], held_q.neg_analog_input};
    if (!diff[12] && (diff > sadc_pkg::DIFF_MAX)) begin
      code = sadc_pkg::positive_fullscale_code;
    end else if (diff[12] && (diff < sadc_pkg::DIFF_MIN)) begin
      code = sadc_pkg::negative_fullscale_code;
    end else begin
      code = diff[11:0];
    end
  end

  // ----------------------------------------------------------------
  // Sample capture
  // ----------------------------------------------------------------
  // Sample is frozen at the frame start, so later input motion is ignored
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      held_q <= '0;
    end else if (csFall && state_q == sadc_pkg::acquire_state) begin
      held_q <= sampleIn;
    end
  end

  // ----------------------------------------------------------------
  // Falling-edge counter
  // ----------------------------------------------------------------
  // Saturates so very long frames do not wrap into a false target
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      edgeCnt_q <= '0;
    end else if (csFall) begin
      edgeCnt_q <= '0;
    end else if (!csN && sclkFall && edgeCnt_q != sadc_pkg::CNT_MAX) begin
      edgeCnt_q <= edgeCnt_q + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  // Only select and serial-clock activity move the state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= sadc_pkg::acquire_state;
    end else begin
      case (state_q)
        sadc_pkg::acquire_state: begin
          if (csFall) begin
            state_q <= sadc_pkg::convert_state;
          end else if (!csN && sclkFall && edgeCnt_q == sadc_pkg::CONV_EDGES) begin
            // A 16th fall after the conversion asks for a normal calibration
            state_q <= sadc_pkg::offset_cal_state;
          end
        end
        sadc_pkg::convert_state: begin
          if (csRise) begin
            state_q <= sadc_pkg::acquire_state;
          end else if (inFirst_q && edgeCnt_q == sadc_pkg::CONV_EDGES) begin
            state_q <= sadc_pkg::offset_cal_state;
          end else if (sclkFall && edgeCnt_q == sadc_pkg::CONV_EDGES) begin
            state_q <= sadc_pkg::offset_cal_state;
          end else if (edgeCnt_q == sadc_pkg::CONV_EDGES && sclkRise) begin
            state_q <= sadc_pkg::acquire_state;
          end
        end
        sadc_pkg::offset_cal_state: begin
          if (csRise) begin
            state_q <= sadc_pkg::acquire_state;
          end else if (inFirst_q && edgeCnt_q == sadc_pkg::CAL_EDGES_FIRST) begin
            state_q <= sadc_pkg::acquire_state;
          end else if (edgeCnt_q == sadc_pkg::CAL_EDGES_NORM) begin
            state_q <= sadc_pkg::acquire_state;
          end
        end
        default: begin
          state_q <= sadc_pkg::acquire_state;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Conversion result and validity
  // ----------------------------------------------------------------
  // A short frame leaves a result flagged invalid for the next frame
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      result_q   <= sadc_pkg::midscale_code;
      resValid_q <= 1'b0;
    end else if (state_q == sadc_pkg::convert_state && sclkFall
                 && edgeCnt_q == sadc_pkg::CONV_EDGES - 7'h01) begin
      result_q   <= code;
      resValid_q <= 1'b1;
    end else if (csRise && state_q == sadc_pkg::convert_state
                 && edgeCnt_q < sadc_pkg::CONV_EDGES) begin
      resValid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power-up frame tracking and calibration status
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      firstFrame_q <= 1'b1;
      inFirst_q    <= 1'b0;
      calDone_q    <= 1'b0;
    end else begin
      if (csFall) begin
        inFirst_q    <= firstFrame_q;
        firstFrame_q <= 1'b0;
      end
      if (state_q == sadc_pkg::offset_cal_state && !csRise
          && ((inFirst_q && edgeCnt_q == sadc_pkg::CAL_EDGES_FIRST)
              || edgeCnt_q == sadc_pkg::CAL_EDGES_NORM)) begin
        calDone_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  // Leading zero at select fall, then the previous result MSB first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_q    <= '0;
      bitsLeft_q <= '0;
      sdoOut_q   <= 1'b0;
      sdoOen_q   <= 1'b1;
    end else if (csN) begin
      sdoOen_q   <= 1'b1;
      sdoOut_q   <= 1'b0;
      bitsLeft_q <= '0;
    end else if (csFall) begin
      shift_q    <= firstFrame_q ? 12'h000 : result_q;
      bitsLeft_q <= 4'hc;
      sdoOut_q   <= 1'b0;
      sdoOen_q   <= 1'b0;
    end else if (sclkRise && edgeCnt_q != 7'h00) begin
      if (bitsLeft_q != 4'h0) begin
        sdoOut_q   <= shift_q[11];
        shift_q    <= {shift_q[10:0], 1'b0};
        bitsLeft_q <= bitsLeft_q - 4'h1;
      end else begin
        sdoOut_q   <= 1'b0;
      end
    end
  end

  assign sdo.sdoOut  = sdoOut_q;
  assign sdo.sdoOen  = sdoOen_q;
  assign state       = state_q;
  assign calDone     = calDone_q;
  assign resultValid = resValid_q;

endmodule

/* File: src/sadc_pkg.sv */
// Shared constants and carrier types for the serial converter frame control.
// Assumes a single 20 MHz system clock; chip select and serial clock are sampled inputs.
package sadc_pkg;

  // ----------------------------------------------------------------
  // Result format
  // ----------------------------------------------------------------
  localparam int          RES_BITS                = 12;           // Result width
  localparam logic [11:0] negative_fullscale_code = 12'h800;      // Most negative code
  localparam logic [11:0] positive_fullscale_code = 12'h7ff;      // Most positive code
  localparam logic [11:0] midscale_code           = 12'h000;      // Zero to one step
  localparam logic [12:0] DIFF_MAX                = 13'h07ff;     // Clamp limit, positive
  localparam logic [12:0] DIFF_MIN                = 13'h1800;     // Clamp limit, negative

  // ----------------------------------------------------------------
  // Frame counts, in serial-clock falling edges
  // ----------------------------------------------------------------
  localparam logic [6:0] CONV_EDGES      = 7'h0f;   // 15 edges finish a conversion
  localparam logic [6:0] CAL_EDGES_FIRST = 7'h18;   // 24 edges: power-up calibration
  localparam logic [6:0] CAL_EDGES_NORM  = 7'h40;   // 64 edges: normal calibration
  localparam logic [6:0] CNT_MAX         = 7'h7f;   // Counter saturation

  // ----------------------------------------------------------------
  // Throughput figures
  // ----------------------------------------------------------------
  localparam int SAMPLE_RATE_KSPS = 3000;           // Up to 3 mega-samples per second
  localparam int CLK_RATE_KHZ     = 20000;          // System clock rate
  localparam int MIN_CYCLE_CLKS   = (CLK_RATE_KHZ + SAMPLE_RATE_KSPS - 1) / SAMPLE_RATE_KSPS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    acquire_state,
    convert_state,
    offset_cal_state
  } sadc_state_e;

  typedef struct packed {
    logic [RES_BITS-1:0] pos_analog_input;          // Digitised positive-input sample
    logic [RES_BITS-1:0] neg_analog_input;          // Digitised negative-input sample
  } sadc_sample_s;

  typedef struct packed {
    logic sdoOut;                                   // Serial data level
    logic sdoOen;                                   // Low while driven
  } sadc_sdo_s;

endpackage

/* File: verification/sadc_frame_ctrl_bench.sv */
// Self-checking bench for the converter frame control.
// Assumes the host model makes select and serial clock; the bench drives samples.
module sadc_frame_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                   clk;
  logic                   resetn;
  logic                   csN;
  logic                   sclk;
  sadc_pkg::sadc_sample_s sampleIn;
  sadc_pkg::sadc_sdo_s    sdo;
  sadc_pkg::sadc_state_e  state;
  logic                   calDone;
  logic                   resultValid;
  logic [15:0]            rx;          // Captured frame bits
  int                     error_cnt;   // Mismatches
  int                     checks;      // Comparisons made
  sadc_frame_ctrl dut (.clk(clk), .resetn(resetn), .csN(csN), .sclk(sclk),
    .sampleIn(sampleIn), .sdo(sdo), .state(state), .calDone(calDone),
    .resultValid(resultValid));
  sadc_host_model host (.clk(clk), .sdo(sdo), .csN(csN), .sclk(sclk));
  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic do_reset;
    resetn <= 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    chk(16'(state), 16'(sadc_pkg::acquire_state), "state after reset");
    chk({15'h0, sdo.sdoOen}, 16'h0001, "data output not released");
    chk({14'h0, calDone, resultValid}, 16'h0000, "flags after reset");
    $display("test reset done");
  endtask
  // First frame shifts zeros; raising select before 24 falls aborts calibration
  task automatic test_first;
    sampleIn <= 24'h100050;
    host.frame(15, rx);
    chk(rx, 16'h0000, "first frame data");
    chk({14'h0, calDone, resultValid}, 16'h0001, "first frame flags");
    chk(16'(state), 16'(sadc_pkg::acquire_state), "first frame state");
    $display("test first frame done");
  endtask
  // Each frame shifts the previous difference; input moves mid-frame to prove capture
  task automatic test_codes;
    logic [23:0] smp [5] = '{24'h7ff800, 24'h8007ff, 24'h123123, 24'h000001, 24'h000000};
    logic [11:0] res [5] = '{12'h7ff, 12'h800, 12'h000, 12'hfff, 12'h000};
    logic [11:0] prev;
    prev = 12'h0b0;
    for (int i = 0; i < 5; i++) begin
      sampleIn <= smp[i];
      fork
        host.frame(15, rx);
        begin
          repeat (8) @(posedge clk);
          sampleIn <= ~smp[i];
        end
      join
      chk(rx, {1'b0, prev, 3'b000}, "shifted code wrong");
      chk({15'h0, resultValid}, 16'h0001, "result flag");
      prev = res[i];
    end
    $display("test codes done");
  endtask
  task automatic test_short;
    host.frame(5, rx);
    chk({15'h0, resultValid}, 16'h0000, "short frame not flagged");
    host.frame(15, rx);
    chk({15'h0, resultValid}, 16'h0001, "full frame not valid");
    $display("test short frame done");
  endtask
  task automatic test_cal;
    host.frame(20, rx);
    chk({15'h0, calDone}, 16'h0000, "aborted calibration done");
    chk(16'(state), 16'(sadc_pkg::acquire_state), "abort state");
    host.frame(64, rx);
    chk({15'h0, calDone}, 16'h0001, "normal calibration missing");
    chk(16'(state), 16'(sadc_pkg::acquire_state), "state after cal");
    $display("test calibration done");
  endtask
  // A fresh power-up frame of 24 falls calibrates and still shifts zeros
  task automatic test_power_cal;
    do_reset;
    host.frame(24, rx);
    chk(rx, 16'h0000, "power-up frame data");
    chk({15'h0, calDone}, 16'h0001, "power-up calibration missing");
    $display("test power-up calibration done");
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    sampleIn = '0;
    error_cnt = 0;
    checks = 0;
    do_reset;
    test_reset;
    test_first;
    test_codes;
    test_short;
    test_cal;
    test_power_cal;
    close_out;
  end
  // Run needs about 1900 cycles; a hang is cut well past that
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out;
  end
endmodule

/* File: verification/sadc_frame_ctrl_chk.sv */
// Port-level assertions for the converter frame control.
// Assumes one clock domain; bound below to every frame control instance.
module sadc_frame_ctrl_chk (
  input wire logic                   clk,
  input wire logic                   resetn,
  input wire logic                   csN,
  input wire logic                   sclk,
  input wire sadc_pkg::sadc_sample_s sampleIn,
  input wire sadc_pkg::sadc_sdo_s    sdo,
  input wire sadc_pkg::sadc_state_e  state,
  input wire logic                   calDone,
  input wire logic                   resultValid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_sdo_released: assert property (csN [*4] |-> sdo.sdoOen)
    else $error("data output driven while select idles");
  a_lead_zero: assert property ($fell(csN) |-> ##[1:3] (!sdo.sdoOen && !sdo.sdoOut))
    else $error("no leading zero after select fall");
  a_reset_acquire: assert property ($rose(resetn) |-> state == sadc_pkg::acquire_state
    && !calDone && !resultValid) else $error("wrong state after reset");
  a_legal_state: assert property (state inside {sadc_pkg::acquire_state,
    sadc_pkg::convert_state, sadc_pkg::offset_cal_state}) else $error("illegal state");
  a_idle_acquire: assert property (csN [*4] |-> state == sadc_pkg::acquire_state)
    else $error("not in acquire between frames");
  a_enter_convert: assert property ($fell(csN) && state == sadc_pkg::acquire_state
    |-> ##[1:3] state == sadc_pkg::convert_state) else $error("frame start not taken");
  // Data may only move shortly after a serial clock rise, never on a fall
  a_bit_launch: assert property (!sdo.sdoOen && !$past(sdo.sdoOen) && $changed(sdo.sdoOut)
    |-> $past(sclk) && !($past(sclk, 2) && $past(sclk, 3) && $past(sclk, 4)))
    else $error("data bit moved without a clock rise");
  a_cal_sticky: assert property (!$fell(calDone))
    else $error("calibration flag lost");
  a_cal_framed: assert property ($rose(calDone) |-> !$past(csN, 2))
    else $error("calibration ended outside a frame");
endmodule

bind sadc_frame_ctrl sadc_frame_ctrl_chk chk (.clk(clk), .resetn(resetn), .csN(csN),
  .sclk(sclk), .sampleIn(sampleIn), .sdo(sdo), .state(state), .calDone(calDone),
  .resultValid(resultValid));

/* File: verification/sadc_host_model.sv */
// Host controller model: makes select and serial clock, captures data bits.
// Assumes a 20 MHz clk; each serial clock level lasts four clk periods.
module sadc_host_model (
  input  wire logic                clk,
  input  wire sadc_pkg::sadc_sdo_s sdo,
  output      logic                csN,
  output      logic                sclk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lastOut;  // Last level the device drove
  logic sdoLvl;   // Level seen on the data line
  // Released line shows the inverse of its last level, so a float never passes for data
  always_ff @(posedge clk) begin
    if (!sdo.sdoOen) begin
      lastOut <= sdo.sdoOut;
    end
  end
  assign sdoLvl = sdo.sdoOen ? ~lastOut : sdo.sdoOut;
  // Both lines idle high; the host alone makes them
  initial begin
    csN = 1'b1;
    sclk = 1'b1;
  end
  // One frame of n falls; rx holds the lead bit, then one bit per rise for the first 15 rises
  task automatic frame(input int n, output logic [15:0] rx);
    rx = '0;
    @(posedge clk);
    csN <= 1'b0;
    repeat (4) @(posedge clk);
    rx[15] = sdoLvl;
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      if (i < 15) begin
        rx[14-i] = sdoLvl;
      end
    end
    csN <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule
